// [verilog/vifc_top.sv]
// video input front-end control: selector, format detect, clocks, clamp, gain loop, decimation
`timescale 1ns/10ps
module vifc_top
    import vifc_pkg::*;
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    // register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    // strap
    input  wire logic       i_output_enable_polarity_strap,
    // crystal edge ticks, one pulse per crystal edge
    input  wire logic       i_clock_port_zero_tick,
    input  wire logic       i_clock_port_one_tick,
    output logic            o_clock_port_zero_osc_en,
    output logic            o_clock_port_one_osc_en,
    // analog front-end status and control
    input  wire logic       i_sync_tip,
    input  wire logic       i_frame_start,
    input  wire logic       i_luma_over_range,
    input  wire logic       i_chroma_over_range,
    output logic      [3:0] o_selector_output,
    output logic            o_clamp,
    output logic      [7:0] o_luma_reference_top,
    output logic      [7:0] o_chroma_reference_top,
    output logic      [2:0] o_format_code,
    // double-rate samples in
    input  wire logic       i_sample_valid,
    output logic            o_sample_ready,
    input  wire vifc_pix_t  i_sample,
    // single-rate samples out
    output logic            o_pix_valid,
    input  wire logic       i_pix_ready,
    output vifc_pix_t       o_pix,
    // output clocks and enables
    output logic            o_double_rate_clock,
    output logic            o_single_rate_clock,
    output logic            o_clk_oe,
    output logic            o_pixel_oe,
    output logic            o_sync_oe
);

    typedef enum logic [3:0] {
        VIFC_GL_IDLE = 4'b0001,
        VIFC_GL_SYNC = 4'b0010,
        VIFC_GL_WAIT = 4'b0100,
        VIFC_GL_MEAS = 4'b1000
    } vifc_gl_state_t;

    vifc_infmt_t    infmt_ff;
    logic [7:0]     gain_tgt_ff;
    vifc_status_t   status_ff;
    vifc_status_t   nxt_status;
    logic [7:0]     rdata_ff;
    logic           strap_done_ff;
    logic           strap_hold_ff;
    logic           sync_q_ff;
    logic [9:0]     line_cnt_ff;
    logic [7:0]     clamp_cnt_ff;
    logic [7:0]     bp_cnt_ff;
    vifc_gl_state_t gl_state_ff;
    vifc_gl_state_t nxt_gl_state;
    logic [7:0]     luma_ref_ff;
    logic [7:0]     chroma_ref_ff;
    logic           dbl_clk_ff;
    logic           sgl_clk_ff;
    logic           phase_ff;
    vifc_pix_t      tap1_ff;
    vifc_pix_t      tap2_ff;

    // named decode wires
    logic           wr_status;
    logic           wr_infmt;
    logic           wr_conv;
    logic           line_start;
    logic           sync_end;
    logic           clk_src;
    logic           sel_tick;
    logic           sample_take;
    logic           push_valid;
    logic           push_ready;
    logic           gain_meas;
    logic           back_porch_high;
    logic           back_porch_low;
    vifc_pix_t      filt;
    logic [7:0]     rd_mux;

    // [1 2 1]/4 on the double-rate stream, zero at half the double rate
    function automatic logic [7:0] lpf3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic [9:0] sum;
        sum  = 10'({2'b00, a} + {1'b0, b, 1'b0} + {2'b00, c} + 10'h002);
        lpf3 = sum[9:2];
    endfunction

    function automatic logic [7:0] step_sat(input logic [7:0] v, input logic up, input logic dn);
        step_sat = v;
        if (up && v != 8'hFF) begin
            step_sat = 8'(v + 8'h01);
        end else if (dn && v != 8'h00) begin
            step_sat = 8'(v - 8'h01);
        end
    endfunction

    // register decode
    assign wr_status = i_reg_wr && (i_reg_addr == VIFC_STATUS_OFS);
    assign wr_infmt  = i_reg_wr && (i_reg_addr == VIFC_INFMT_OFS);
    assign wr_conv   = i_reg_wr && (i_reg_addr == VIFC_CONV_IF_OFS);
    assign rd_mux    = (i_reg_addr == VIFC_STATUS_OFS)  ? {2'b00, status_ff.clk_src, status_ff.line_fmt,
                                                           2'b00, status_ff.chroma_ovf, status_ff.luma_ovf} :
                       (i_reg_addr == VIFC_INFMT_OFS)   ? {1'b0, infmt_ff[6:0]} :
                       (i_reg_addr == VIFC_CONV_IF_OFS) ? gain_tgt_ff : 8'h00;

    // clock selection: manual bit when auto detect is off
    assign clk_src = infmt_ff.auto_en ? status_ff.line_fmt : infmt_ff.man_clk;
    assign sel_tick = clk_src ? i_clock_port_one_tick : i_clock_port_zero_tick;

    // sticky flags: a new event wins over a software clear
    always_comb begin
        nxt_status            = status_ff;
        if (wr_status && i_reg_wdata[VIFC_ST_LUMA_OVF_BIT]) begin
            nxt_status.luma_ovf = 1'b0;
        end
        if (wr_status && i_reg_wdata[VIFC_ST_CHROMA_OVF_BIT]) begin
            nxt_status.chroma_ovf = 1'b0;
        end
        if (i_luma_over_range) begin
            nxt_status.luma_ovf = 1'b1;
        end
        if (i_chroma_over_range) begin
            nxt_status.chroma_ovf = 1'b1;
        end
        if (i_frame_start && infmt_ff.auto_en) begin
            nxt_status.line_fmt = (line_cnt_ff > VIFC_LINE_THRESH);
        end
        nxt_status.clk_src = clk_src;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            infmt_ff    <= {1'b0, VIFC_FMT_NTSC_M, VIFC_MAN_CLK_RST, VIFC_AUTO_RST, VIFC_SEL_RST};
            gain_tgt_ff <= VIFC_GAIN_TGT_RST;
            status_ff   <= '0;
            rdata_ff    <= 8'h00;
        end else begin
            if (wr_infmt) begin
                infmt_ff <= {1'b0, i_reg_wdata[6:0]};
            end
            if (wr_conv) begin
                gain_tgt_ff <= i_reg_wdata;
            end
            status_ff <= nxt_status;
            if (i_reg_rd) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // strap is caught on the first edge after release, then held until the next reset
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_done_ff <= 1'b0;
            strap_hold_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            strap_hold_ff <= i_output_enable_polarity_strap;
        end
    end

    // line counting between frame boundaries
    assign line_start = i_sync_tip && !sync_q_ff;
    assign sync_end   = !i_sync_tip && sync_q_ff;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_q_ff   <= 1'b0;
            line_cnt_ff <= 10'h000;
        end else begin
            sync_q_ff <= i_sync_tip;
            if (i_frame_start) begin
                line_cnt_ff <= {9'h000, line_start};
            end else if (line_start && line_cnt_ff != 10'h3FF) begin
                line_cnt_ff <= 10'(line_cnt_ff + 10'h001);
            end
        end
    end

    // clamp: limited to the sync tip, reset at every line start
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            clamp_cnt_ff <= 8'h00;
        end else if (line_start) begin
            clamp_cnt_ff <= VIFC_CLAMP_CYCLES;
        end else if (!i_sync_tip) begin
            clamp_cnt_ff <= 8'h00;
        end else if (clamp_cnt_ff != 8'h00) begin
            clamp_cnt_ff <= 8'(clamp_cnt_ff - 8'h01);
        end
    end
    assign o_clamp = sync_q_ff && (clamp_cnt_ff != 8'h00);

    // gain loop: one reference step per line, taken on the back porch
    assign gain_meas       = (gl_state_ff == VIFC_GL_MEAS) && sample_take;
    assign back_porch_high = gain_meas && (i_sample.luma > gain_tgt_ff);
    assign back_porch_low  = gain_meas && (i_sample.luma < gain_tgt_ff);

    always_comb begin
        nxt_gl_state = gl_state_ff;
        unique case (gl_state_ff)
            VIFC_GL_IDLE: begin
                if (line_start) begin
                    nxt_gl_state = VIFC_GL_SYNC;
                end
            end
            VIFC_GL_SYNC: begin
                if (sync_end) begin
                    nxt_gl_state = VIFC_GL_WAIT;
                end
            end
            VIFC_GL_WAIT: begin
                if (line_start) begin
                    nxt_gl_state = VIFC_GL_SYNC;
                end else if (bp_cnt_ff == 8'h00) begin
                    nxt_gl_state = VIFC_GL_MEAS;
                end
            end
            VIFC_GL_MEAS: begin
                if (line_start) begin
                    nxt_gl_state = VIFC_GL_SYNC;
                end else if (sample_take) begin
                    nxt_gl_state = VIFC_GL_IDLE;
                end
            end
            default: begin
                nxt_gl_state = VIFC_GL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            gl_state_ff   <= VIFC_GL_IDLE;
            bp_cnt_ff     <= 8'h00;
            luma_ref_ff   <= VIFC_REF_TOP_RST;
            chroma_ref_ff <= VIFC_REF_TOP_RST;
        end else begin
            gl_state_ff <= nxt_gl_state;
            bp_cnt_ff   <= (gl_state_ff == VIFC_GL_SYNC) ? VIFC_BP_CYCLES :
                           (bp_cnt_ff != 8'h00) ? 8'(bp_cnt_ff - 8'h01) : 8'h00;
            // a high back porch code means too much gain: raise the ladder top
            luma_ref_ff   <= step_sat(luma_ref_ff, back_porch_high, back_porch_low);
            chroma_ref_ff <= step_sat(chroma_ref_ff, back_porch_high, back_porch_low);
        end
    end

    // output clocks from the selected crystal edges
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            dbl_clk_ff <= 1'b0;
            sgl_clk_ff <= 1'b0;
        end else if (sel_tick) begin
            dbl_clk_ff <= !dbl_clk_ff;
            if (!dbl_clk_ff) begin
                sgl_clk_ff <= !sgl_clk_ff;
            end
        end
    end

    // filter and decimate by two; the sample source stalls while the buffer is full
    assign sample_take = i_sample_valid && push_ready;
    assign push_valid  = i_sample_valid && phase_ff;
    assign filt.luma   = lpf3(i_sample.luma, tap1_ff.luma, tap2_ff.luma);
    assign filt.chroma = lpf3(i_sample.chroma, tap1_ff.chroma, tap2_ff.chroma);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_ff <= 1'b0;
            tap1_ff  <= '0;
            tap2_ff  <= '0;
        end else if (sample_take) begin
            phase_ff <= !phase_ff;
            tap1_ff  <= i_sample;
            tap2_ff  <= tap1_ff;
        end
    end

    vifc_buf2 #(
        .WIDTH ($bits(vifc_pix_t)),
        .DEPTH (2)
    ) u_buf (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_in_valid  (push_valid),
        .o_in_ready  (push_ready),
        .i_in_data   (filt),
        .o_out_valid (o_pix_valid),
        .i_out_ready (i_pix_ready),
        .o_out_data  (o_pix)
    );

    // outputs
    assign o_sample_ready           = push_ready;
    assign o_reg_rdata              = rdata_ff;
    assign o_selector_output        = 4'h1 << infmt_ff.sel;
    assign o_clock_port_zero_osc_en = !clk_src;
    assign o_clock_port_one_osc_en  = clk_src;
    assign o_luma_reference_top     = luma_ref_ff;
    assign o_chroma_reference_top   = chroma_ref_ff;
    assign o_format_code            = infmt_ff.fmt_code;
    assign o_double_rate_clock      = dbl_clk_ff;
    assign o_single_rate_clock      = sgl_clk_ff;
    assign o_clk_oe                 = strap_done_ff && !strap_hold_ff;
    assign o_pixel_oe               = strap_done_ff && !strap_hold_ff;
    assign o_sync_oe                = strap_done_ff && !strap_hold_ff;

    sel_onehot_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $onehot(o_selector_output) && o_selector_output[infmt_ff.sel]) else $error("selector not one-hot");
    clk_source_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        infmt_ff.auto_en |-> (o_clock_port_one_osc_en == status_ff.line_fmt)) else $error("wrong clock source");
    fmt_frame_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $changed(status_ff.line_fmt) |-> $past(i_frame_start)) else $error("format flag moved mid-frame");
    luma_ovf_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_luma_over_range |=> status_ff.luma_ovf) else $error("luma overflow not flagged");
    clamp_tip_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $rose(sync_q_ff) |-> o_clamp) else $error("no clamp at sync tip");
    clamp_bound_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_clamp |-> i_sync_tip || !sync_q_ff || $past(sync_q_ff)) else $error("clamp outside sync tip");
    osc_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_clock_port_zero_osc_en != o_clock_port_one_osc_en
        && status_ff.clk_src == $past(o_clock_port_one_osc_en)) else $error("oscillator enable or source status wrong");
    gain_up_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        back_porch_high && luma_ref_ff != 8'hFF |=> luma_ref_ff == $past(luma_ref_ff) + 8'h01)
        else $error("gain loop did not step");
    dbl_clk_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        sel_tick ##1 sel_tick |=> o_single_rate_clock != $past(o_single_rate_clock, 2)
        || o_double_rate_clock != $past(o_double_rate_clock, 2)) else $error("clock divider stuck");
    strap_oe_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        strap_hold_ff |-> !o_clk_oe && !o_pixel_oe && !o_sync_oe) else $error("outputs driven with strap high");
    decim_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        sample_take ##1 sample_take[*1] |-> phase_ff != $past(phase_ff)) else $error("decimation phase stuck");

endmodule

// [pkg/vifc_pkg.sv]
// shared constants and types of the video input front-end control
package vifc_pkg;

    // register offsets
    localparam logic [7:0] VIFC_STATUS_OFS     = 8'h00;
    localparam logic [7:0] VIFC_INFMT_OFS      = 8'h01;
    localparam logic [7:0] VIFC_CONV_IF_OFS    = 8'h1A;

    // status register bit positions
    localparam int VIFC_ST_LUMA_OVF_BIT        = 0;
    localparam int VIFC_ST_CHROMA_OVF_BIT      = 1;
    localparam int VIFC_ST_LINE_FMT_BIT        = 4;
    localparam int VIFC_ST_CLK_SRC_BIT         = 5;

    // input format register fields
    localparam int VIFC_IF_SEL_LSB             = 0;
    localparam int VIFC_IF_AUTO_BIT            = 2;
    localparam int VIFC_IF_MAN_CLK_BIT         = 3;
    localparam int VIFC_IF_FMT_LSB             = 4;

    // reset values
    localparam logic [1:0] VIFC_SEL_RST        = 2'h0;
    localparam logic       VIFC_AUTO_RST       = 1'b1;
    localparam logic       VIFC_MAN_CLK_RST    = 1'b0;
    localparam logic [2:0] VIFC_FMT_NTSC_M     = 3'h1;
    localparam logic [7:0] VIFC_GAIN_TGT_RST   = 8'h38;
    localparam logic [7:0] VIFC_REF_TOP_RST    = 8'h80;

    // line count between 525 and 625 line frames
    localparam logic [9:0] VIFC_LINE_THRESH    = 10'h23F;

    // timing
    localparam int VIFC_CLK_PERIOD_NS          = 10;
    localparam int VIFC_CLAMP_TIME_NS          = 2000;
    localparam int VIFC_BP_DELAY_NS            = 1500;
    localparam int VIFC_CLAMP_CYCLES_I         = (VIFC_CLAMP_TIME_NS / VIFC_CLK_PERIOD_NS < 1) ? 1
                                                 : VIFC_CLAMP_TIME_NS / VIFC_CLK_PERIOD_NS;
    localparam int VIFC_BP_CYCLES_I            = (VIFC_BP_DELAY_NS + VIFC_CLK_PERIOD_NS - 1)
                                                 / VIFC_CLK_PERIOD_NS;
    localparam logic [7:0] VIFC_CLAMP_CYCLES   = 8'(VIFC_CLAMP_CYCLES_I);
    localparam logic [7:0] VIFC_BP_CYCLES      = 8'(VIFC_BP_CYCLES_I);

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } vifc_pix_t;

    typedef struct packed {
        logic       reserved;
        logic [2:0] fmt_code;
        logic       man_clk;
        logic       auto_en;
        logic [1:0] sel;
    } vifc_infmt_t;

    typedef struct packed {
        logic clk_src;
        logic line_fmt;
        logic chroma_ovf;
        logic luma_ovf;
    } vifc_status_t;

endpackage

// [verilog/vifc_buf2.sv]
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module vifc_buf2
    import vifc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign o_in_ready  = (count_ff != CW'(DEPTH));
    assign o_out_valid = (count_ff != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= i_in_data;
                wr_ptr_ff         <= ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (push && !pop) begin
                count_ff <= CW'(count_ff + 1'b1);
            end else if (pop && !push) begin
                count_ff <= CW'(count_ff - 1'b1);
            end
        end
    end

endmodule

// [verif/vifc_video_src.sv]
// stand-in for the video source and crystals: sync tips, frame marks, ticks
`timescale 1ns/10ps
module vifc_video_src (
    // clock and frame shape
    input  wire logic       i_mclk,
    input  wire logic [9:0] i_lines,
    input  wire logic       i_long,
    // source side
    output logic            o_sync_tip,
    output logic            o_frame_start,
    output logic            o_tick0,
    output logic            o_tick1
);
    logic [8:0] pos_ff = 9'h000;
    logic [9:0] line_ff = 10'h000;
    // eight-cycle lines keep a full frame at 4200 or 5000 cycles; long lines leave room for the back porch
    always @(posedge i_mclk) begin
        #1 pos_ff = (pos_ff == (i_long ? 9'h1FF : 9'h007)) ? 9'h000 : pos_ff + 9'h001;
        if (pos_ff == 9'h000) line_ff = (line_ff + 10'h001 >= i_lines) ? 10'h000 : line_ff + 10'h001;
    end
    assign o_sync_tip    = pos_ff < 9'h002;
    assign o_frame_start = pos_ff == 9'h000 && line_ff == 10'h000;
    // both ports tick without pause
    assign o_tick0       = pos_ff[0];
    assign o_tick1       = pos_ff[0] | pos_ff[1];
endmodule

// [verif/vifc_top_tb_top.sv]
// self-checking bench: registers, detection, overflow, strap, sample stream
`timescale 1ns/10ps
module vifc_top_tb_top;
    import vifc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rd_q = 1'b0, strap = 1'b0;
    logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat, expq[$];
    logic        s_valid = 1'b0, s_ready, p_valid, p_ready = 1'b0, clamp, lovr = 1'b0, covr = 1'b0;
    logic        tip, fstart, tk0, tk1, osc0, osc1, ck_oe, px_oe, sy_oe;
    logic [3:0]  sel;
    logic [2:0]  fmt;
    logic [7:0]  lref, chroma_reference_top;
    logic        dck, sck, long_ln = 1'b0;
    int          ntick = 0, lc = 0;
    logic [9:0]  lines = 10'd525;
    logic [16:0] rnd = 17'd93720;
    vifc_pix_t   smp = '0, pix, h1 = '0, h2 = '0, pixq[$];
    int          failures = 0, checks = 0, nsmp = 0, clamps = 0, cyc = 0, i, n;
    vifc_top i_vifc_top (.i_mclk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdat),
        .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdat), .i_output_enable_polarity_strap(strap),
        .i_clock_port_zero_tick(tk0), .i_clock_port_one_tick(tk1), .o_clock_port_zero_osc_en(osc0),
        .o_clock_port_one_osc_en(osc1), .i_sync_tip(tip), .i_frame_start(fstart),
        .i_luma_over_range(lovr), .i_chroma_over_range(covr), .o_selector_output(sel), .o_clamp(clamp),
        .o_luma_reference_top(lref), .o_chroma_reference_top(chroma_reference_top), .o_format_code(fmt), .i_sample_valid(s_valid),
        .o_sample_ready(s_ready), .i_sample(smp), .o_pix_valid(p_valid), .i_pix_ready(p_ready),
        .o_pix(pix), .o_double_rate_clock(dck), .o_single_rate_clock(sck), .o_clk_oe(ck_oe),
        .o_pixel_oe(px_oe), .o_sync_oe(sy_oe));
    vifc_video_src i_vifc_video_src (.i_mclk(clk), .i_lines(lines), .i_long(long_ln), .o_sync_tip(tip),
        .o_frame_start(fstart), .o_tick0(tk0), .o_tick1(tk1));
    always #5 clk = ~clk;
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [7:0] lpf(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        return 8'(({2'b00, a} + {1'b0, b, 1'b0} + {2'b00, c}) >> 2);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            failures++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {addr, wdat, wr_s} = {a, d, 1'b1};
        @(posedge clk);
        #1 wr_s = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 {addr, rd_s} = {a, 1'b1};
        expq.push_back(e);
        @(posedge clk);
        #1 rd_s = 1'b0;
    endtask
    // valid is held across calls so samples go back to back
    task automatic send(input vifc_pix_t s);
        int k;
        {smp, s_valid} = {s, 1'b1};
        for (k = 0; s_ready !== 1'b1; k++) begin
            tmo(k, 200);
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        nsmp++;
        if (nsmp % 2 == 0) pixq.push_back({lpf(s.luma, h1.luma, h2.luma), lpf(s.chroma, h1.chroma, h2.chroma)});
        {h2, h1} = {h1, s};
        #1;
    endtask
    always @(posedge clk) begin
        rd_q <= rd_s;
        cyc <= cyc + 1;
        clamps <= clamps + int'(clamp === 1'b1);
        // selected crystal edges seen since reset
        ntick <= rstn ? ntick + int'((osc1 ? tk1 : tk0) === 1'b1) : 0;
        #1 p_ready = cyc[1] | cyc[3];
    end
    always @(negedge clk) if (rd_q) chk(16'(rdat), 16'(expq.pop_front()));
    always @(negedge clk) if (rstn) chk(16'({dck, sck}), 16'({ntick[0], ntick[1] ^ ntick[0]}));
    always @(posedge clk) if (p_valid === 1'b1 && p_ready) chk(pix, pixq.pop_front());
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(16'({fmt, ck_oe, px_oe, sy_oe, osc1, osc0}), 16'({VIFC_FMT_NTSC_M, 5'h1D}));
        rd(VIFC_INFMT_OFS, 8'h14);
        rd(VIFC_CONV_IF_OFS, 8'h38);
        rnd = lfsr(rnd);
        wr(VIFC_CONV_IF_OFS, rnd[7:0]);
        wr(8'h55, 8'hFF);
        rd(VIFC_CONV_IF_OFS, rnd[7:0]);
        rd(8'h55, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(VIFC_INFMT_OFS, 8'h94 | 8'(i));
            rd(VIFC_INFMT_OFS, 8'h14 | 8'(i));
            chk(16'(sel), 16'(1 << i));
        end
        @(posedge clk);
        #1 lovr = 1'b1;
        @(posedge clk);
        #1 {lovr, covr} = 2'b01;
        @(posedge clk);
        #1 covr = 1'b0;
        rd(VIFC_STATUS_OFS, 8'h03);
        wr(VIFC_STATUS_OFS, 8'h03);
        rd(VIFC_STATUS_OFS, 8'h00);
        @(posedge clk);
        #1;
        for (i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            send({rnd[7:0] & 8'hFC, rnd[15:8] & 8'hFC});
        end
        s_valid = 1'b0;
        for (n = 0; pixq.size() != 0; n++) begin
            tmo(n, 200);
            @(posedge clk);
        end
        for (n = 0; fstart !== 1'b1; n++) begin
            tmo(n, 6000);
            @(posedge clk);
        end
        #1 lines = 10'd625;
        repeat (100) @(posedge clk);
        rd(VIFC_STATUS_OFS, 8'h00);
        for (n = 0; osc1 !== 1'b1; n++) begin
            tmo(n, 12000);
            @(posedge clk);
        end
        #1 rd(VIFC_STATUS_OFS, 8'h30);
        chk(16'({osc1, osc0}), 16'h0002);
        wr(VIFC_INFMT_OFS, 8'h10);
        rd(VIFC_STATUS_OFS, 8'h10);
        chk(16'({osc1, osc0}), 16'h0001);
        chk(16'(clamps > 0), 16'h0001);
        // long lines: the gain loop gets its back porch; two lines give two steps
        long_ln = 1'b1;
        wr(VIFC_CONV_IF_OFS, VIFC_GAIN_TGT_RST);
        for (n = 0; tip !== 1'b1; n++) begin
            tmo(n, 600);
            @(posedge clk);
        end
        #1 chk(16'({lref, chroma_reference_top}), 16'({VIFC_REF_TOP_RST, VIFC_REF_TOP_RST}));
        rnd = lfsr(rnd);
        lc = cyc;
        while (cyc - lc < 1090) send({8'hFC, rnd[15:8] & 8'hFC});
        s_valid = 1'b0;
        chk(16'({lref, chroma_reference_top}), 16'({VIFC_REF_TOP_RST + 8'h02, VIFC_REF_TOP_RST + 8'h02}));
        for (n = 0; pixq.size() != 0; n++) begin
            tmo(n, 200);
            @(posedge clk);
        end
        #1 {rstn, strap} = 2'b01;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(16'({ck_oe, px_oe, sy_oe}), 16'h0000);
        rd(VIFC_INFMT_OFS, 8'h14);
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule
